/* File: sih_pkg.sv */
package sih_pkg;
  // Datagram subfunction codes accepted by the unit
  localparam logic [7:0] SF_RD_CFG = 8'h02;
  localparam logic [7:0] SF_PULSE = 8'h10;
  localparam logic [7:0] SF_FORCE_BSM = 8'h1a;
  localparam logic [7:0] SF_UNFORCE_BSM = 8'h1b;
  localparam logic [7:0] SF_RD_MAP = 8'h2a;
  localparam logic [7:0] SF_WR_MAP = 8'h2c;
  localparam logic [7:0] SF_RD_FORCE = 8'h40;
  localparam logic [7:0] SF_RD_DIAG = 8'h42;
  localparam logic [7:0] SF_FORCE_PT = 8'h50;
  localparam logic [7:0] SF_UNFORCE_PT = 8'h51;
  // Reply subfunction codes
  localparam logic [7:0] SF_CFG_RPLY = 8'h03;
  localparam logic [7:0] SF_PULSE_DONE = 8'h11;
  localparam logic [7:0] SF_CFG_CHG = 8'h1d;
  localparam logic [7:0] SF_MAP_RPLY = 8'h2b;
  localparam logic [7:0] SF_FORCE_RPLY = 8'h41;
  localparam logic [7:0] SF_DIAG_RPLY = 8'h43;
  // Data words: inputs first, then outputs, then the switching module
  localparam int NWORDS = 7;
  localparam int NIN = 3;
  localparam int NOUT = 3;
  localparam logic [2:0] W_DI = 3'h0;
  localparam logic [2:0] W_AI0 = 3'h1;
  localparam logic [2:0] W_AI1 = 3'h2;
  localparam logic [2:0] W_DQ = 3'h3;
  localparam logic [2:0] W_AQ1 = 3'h5;
  localparam logic [2:0] W_BSM = 3'h6;
  localparam logic [15:0] REFS_PER_REG = 16'h0010;
  localparam logic [3:0] NV_LAST = 4'hd;
  localparam logic [15:0] MAP_START_RST = 16'h0001;
  localparam logic [7:0] LEN_DI_RST = 8'h02;
  localparam logic [7:0] LEN_AI_RST = 8'h04;
  localparam logic [7:0] LEN_DQ_RST = 8'h02;
  localparam logic [7:0] LEN_AQ_RST = 8'h04;
  localparam logic [15:0] DEFAULT_OUT = 16'h0000;
  // Pulse test duration
  localparam int CLK_NS = 20;
  localparam int PULSE_TEST_NS = 100000;
  localparam int PULSE_TEST_CYC = PULSE_TEST_NS / CLK_NS;

  typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_REPLY} sih_state_t;
  typedef enum logic [2:0] {RK_CFG, RK_PULSE, RK_CHG, RK_MAP, RK_FORCE, RK_DIAG} sih_rkind_t;

  function automatic logic [3:0] rply_len(input sih_rkind_t k);
    rply_len = (k == RK_MAP) ? 4'h8 : (k == RK_FORCE) ? 4'h7 : 4'h1;
  endfunction : rply_len

  function automatic logic [7:0] rply_code(input sih_rkind_t k);
    case (k)
      RK_CFG: rply_code = SF_CFG_RPLY;
      RK_PULSE: rply_code = SF_PULSE_DONE;
      RK_CHG: rply_code = SF_CFG_CHG;
      RK_MAP: rply_code = SF_MAP_RPLY;
      RK_FORCE: rply_code = SF_FORCE_RPLY;
      default: rply_code = SF_DIAG_RPLY;
    endcase
  endfunction : rply_code
endpackage : sih_pkg

/* File: sih_force_store.sv */
`timescale 1ns/1ps
module sih_force_store (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic wr_en, // Update one force word
  input wire logic [2:0] wr_idx, // Word index
  input wire logic [15:0] wr_mask, // New force mask
  input wire logic [15:0] wr_val, // New force value
  output logic [sih_pkg::NWORDS-1:0][15:0] mask_o, // Force masks
  output logic [sih_pkg::NWORDS-1:0][15:0] val_o, // Force values
  output logic ready_o, // Restored and not writing
  output logic nv_we, // Nonvolatile write strobe
  output logic [3:0] nv_addr, // Nonvolatile address
  output logic [15:0] nv_wdata, // Nonvolatile write data
  input wire logic [15:0] nv_rdata // Nonvolatile read data, same cycle
);
  logic [sih_pkg::NWORDS-1:0][15:0] mask_ff;
  logic [sih_pkg::NWORDS-1:0][15:0] val_ff;
  logic restoring_ff;
  logic [3:0] rcnt_ff;
  logic [1:0] ph_ff;
  logic [2:0] idx_ff;
  wire [2:0] rword = rcnt_ff[3:1];

  assign mask_o = mask_ff;
  assign val_o = val_ff;
  assign ready_o = ~restoring_ff & (ph_ff == 2'h0);
  assign nv_we = (ph_ff != 2'h0);
  assign nv_addr = restoring_ff ? rcnt_ff : {idx_ff, ph_ff == 2'h2};
  assign nv_wdata = (ph_ff == 2'h2) ? val_ff[idx_ff] : mask_ff[idx_ff];

  // Forces come back from nonvolatile storage after every reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_ff <= '0;
      val_ff <= '0;
      restoring_ff <= 1'b1;
      rcnt_ff <= 4'h0;
      ph_ff <= 2'h0;
      idx_ff <= 3'h0;
    end
    else if (restoring_ff)
    begin
      if (rcnt_ff[0])
        val_ff[rword] <= nv_rdata;
      else
        mask_ff[rword] <= nv_rdata;
      rcnt_ff <= rcnt_ff + 4'h1;
      restoring_ff <= (rcnt_ff != sih_pkg::NV_LAST);
    end
    else if (ph_ff != 2'h0)
      ph_ff <= (ph_ff == 2'h1) ? 2'h2 : 2'h0;
    else if (wr_en)
    begin
      // Each change is written through to nonvolatile storage
      mask_ff[wr_idx] <= wr_mask;
      val_ff[wr_idx] <= wr_val;
      idx_ff <= wr_idx;
      ph_ff <= 2'h1;
    end
  end
endmodule : sih_force_store

/* File: sih_station_handler.sv */
`timescale 1ns/1ps
module sih_station_handler #(
  parameter int PULSE_CYC = sih_pkg::PULSE_TEST_CYC
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic dg_valid, // Incoming datagram present
  output logic dg_ready, // Datagram can be taken
  input wire logic [7:0] dg_subfn, // Subfunction code
  input wire logic dg_from_hhm, // Sender is handheld_monitor
  input wire logic [2:0] dg_word, // Word index or map type
  input wire logic [3:0] dg_bit, // Point within a discrete word
  input wire logic [15:0] dg_value, // Force value or map start
  input wire logic [7:0] dg_len, // Map length in bytes
  input wire logic hhm_force_en, // Monitor forcing capability enabled
  input wire logic [15:0] cfg_data, // Station configuration word
  input wire logic [15:0] slot_diag, // Slot diagnostics word
  output logic rp_valid, // Reply word present
  input wire logic rp_ready, // Reply word taken
  output logic [7:0] rp_subfn, // Reply subfunction code
  output logic [15:0] rp_data, // Reply word
  output logic rp_last, // Last reply word
  output logic pulse_run, // Pulse test in progress
  input wire logic [15:0] field_di, // Field discrete inputs (pins)
  input wire logic [15:0] field_ai0, // Field analog channel 0 (pins)
  input wire logic [15:0] field_ai1, // Field analog channel 1 (pins)
  input wire logic host_online, // Host outputs are arriving
  input wire logic hold_last, // Outputs hold last state when offline
  input wire logic ho_valid, // Host output word present
  input wire logic ho_first, // First host output word of a scan
  input wire logic [15:0] ho_data, // Host output word
  output logic [15:0] out_dq, // Physical discrete outputs
  output logic [15:0] out_aq0, // Physical analog output 0
  output logic [15:0] out_aq1, // Physical analog output 1
  input wire logic scan_start, // Bus scan begins
  output logic sc_valid, // Scan input word present
  input wire logic sc_ready, // Scan input word taken
  output logic [15:0] sc_data, // Scan input word
  output logic sc_last, // Last scan input word
  output logic [95:0] mod_ref, // Module start references, six words
  output logic [15:0] bsm_force_val, // Switching module forced values
  output logic [15:0] bsm_force_mask, // Switching module forced points
  output logic forced_active, // At least one point forced
  output logic nv_we, // Nonvolatile write strobe
  output logic [3:0] nv_addr, // Nonvolatile address
  output logic [15:0] nv_wdata, // Nonvolatile write data
  input wire logic [15:0] nv_rdata // Nonvolatile read data
);
  localparam logic [12:0] PULSE_LAST = 13'(PULSE_CYC - 1);

  sih_pkg::sih_state_t state_ff, nxt_state;
  sih_pkg::sih_rkind_t kind_ff, nxt_kind, rep_kind;
  logic [3:0] idx_ff, nxt_idx;
  logic [12:0] cnt_ff, nxt_cnt;
  logic [15:0] rp_data_ff, nxt_word;
  logic [7:0] rp_subfn_ff;
  logic [3:0][15:0] start_ff;
  logic [3:0][7:0] len_ff;
  logic [2:0][15:0] sy1_ff, sy2_ff, host_ff, last_ff, out_ff;
  logic [1:0] ho_idx_ff;
  logic sc_busy_ff;
  logic [1:0] sc_idx_ff;
  logic [15:0] sc_data_ff;
  logic [5:0][15:0] mod_ref_ff, nxt_ref;
  logic forced_ff;
  logic [sih_pkg::NWORDS-1:0][15:0] st_mask, st_val;
  logic st_ready;
  logic [2:0][15:0] eff_in, eff_out;

  // Datagram decode
  wire take = dg_valid & dg_ready;
  wire sf_bsm = (dg_subfn == sih_pkg::SF_FORCE_BSM) | (dg_subfn == sih_pkg::SF_UNFORCE_BSM);
  wire [2:0] tw = sf_bsm ? sih_pkg::W_BSM : dg_word;
  wire pt_ok = (dg_word < sih_pkg::W_BSM);
  wire force_ok = ~dg_from_hhm | hhm_force_en;
  wire hhm_ok = dg_from_hhm & hhm_force_en;
  wire is_disc = (tw == sih_pkg::W_DI) | (tw == sih_pkg::W_DQ) | (tw == sih_pkg::W_BSM);
  wire [15:0] bitsel = 16'h0001 << dg_bit;
  wire [2:0] wsel = (tw < 3'(sih_pkg::NWORDS)) ? tw : 3'h0;
  wire [15:0] cur_mask = st_mask[wsel];
  wire [15:0] cur_val = st_val[wsel];
  wire sf_force = (dg_subfn == sih_pkg::SF_FORCE_BSM) | ((dg_subfn == sih_pkg::SF_FORCE_PT) & pt_ok);
  wire sf_unf = (dg_subfn == sih_pkg::SF_UNFORCE_BSM) | ((dg_subfn == sih_pkg::SF_UNFORCE_PT) & pt_ok);
  wire do_force = take & sf_force & force_ok;
  wire do_unforce = take & sf_unf & hhm_ok;
  wire [15:0] set_val = (cur_val & ~bitsel) | (dg_value[0] ? bitsel : 16'h0000);
  wire [15:0] new_mask = do_force ? (is_disc ? (cur_mask | bitsel) : 16'hffff)
                                  : (is_disc ? (cur_mask & ~bitsel) : 16'h0000);
  wire [15:0] new_val = do_force ? (is_disc ? set_val : dg_value) : cur_val;
  wire bsm_last = do_unforce & sf_bsm & (cur_mask != 16'h0000) & (new_mask == 16'h0000);
  wire go_cfg = take & (dg_subfn == sih_pkg::SF_RD_CFG);
  wire go_map = take & (dg_subfn == sih_pkg::SF_RD_MAP);
  wire go_frc = take & (dg_subfn == sih_pkg::SF_RD_FORCE) & ~dg_from_hhm;
  wire go_diag = take & (dg_subfn == sih_pkg::SF_RD_DIAG) & ~dg_from_hhm;
  wire go_chg = (do_force & sf_bsm) | bsm_last;
  wire go_pulse = take & (dg_subfn == sih_pkg::SF_PULSE) & dg_from_hhm;
  wire wr_map = take & (dg_subfn == sih_pkg::SF_WR_MAP) & (dg_word < 3'h4);
  wire rep_go = go_cfg | go_map | go_frc | go_diag | go_chg;
  wire [3:0] last_idx = sih_pkg::rply_len(kind_ff) - 4'h1;

  // Anything not decoded above is taken and dropped silently
  assign dg_ready = (state_ff == sih_pkg::ST_IDLE) & st_ready;
  assign rp_valid = (state_ff == sih_pkg::ST_REPLY);
  assign rp_last = (idx_ff == last_idx);
  assign rp_data = rp_data_ff;
  assign rp_subfn = rp_subfn_ff;
  assign pulse_run = (state_ff == sih_pkg::ST_PULSE);
  assign sc_valid = sc_busy_ff;
  assign sc_last = (sc_idx_ff == 2'(sih_pkg::NIN - 1));
  assign sc_data = sc_data_ff;
  assign out_dq = out_ff[0];
  assign out_aq0 = out_ff[1];
  assign out_aq1 = out_ff[2];
  assign mod_ref = mod_ref_ff;
  assign forced_active = forced_ff;
  assign bsm_force_mask = st_mask[sih_pkg::W_BSM];
  assign bsm_force_val = st_val[sih_pkg::W_BSM];

  always_comb
  begin
    if (go_cfg)
      rep_kind = sih_pkg::RK_CFG;
    else if (go_map)
      rep_kind = sih_pkg::RK_MAP;
    else if (go_frc)
      rep_kind = sih_pkg::RK_FORCE;
    else if (go_diag)
      rep_kind = sih_pkg::RK_DIAG;
    else
      rep_kind = sih_pkg::RK_CHG;
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_idx = idx_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      sih_pkg::ST_IDLE:
      begin
        if (go_pulse)
        begin
          nxt_state = sih_pkg::ST_PULSE;
          nxt_cnt = PULSE_LAST;
        end
        else if (rep_go)
        begin
          nxt_state = sih_pkg::ST_REPLY;
          nxt_kind = rep_kind;
          nxt_idx = 4'h0;
        end
      end
      sih_pkg::ST_PULSE:
      begin
        if (cnt_ff == 13'h0000)
        begin
          nxt_state = sih_pkg::ST_REPLY;
          nxt_kind = sih_pkg::RK_PULSE;
          nxt_idx = 4'h0;
        end
        else
          nxt_cnt = cnt_ff - 13'h0001;
      end
      sih_pkg::ST_REPLY:
      begin
        if (rp_ready)
        begin
          if (idx_ff == last_idx)
            nxt_state = sih_pkg::ST_IDLE;
          else
            nxt_idx = idx_ff + 4'h1;
        end
      end
      default: nxt_state = sih_pkg::ST_IDLE;
    endcase
  end

  // Reply word for the next reply position
  always_comb
  begin
    case (nxt_kind)
      sih_pkg::RK_CFG: nxt_word = cfg_data;
      sih_pkg::RK_MAP: nxt_word = nxt_idx[0] ? {8'h00, len_ff[nxt_idx[2:1]]}
                                            : start_ff[nxt_idx[2:1]];
      sih_pkg::RK_FORCE: nxt_word = (nxt_idx < 4'(sih_pkg::NWORDS)) ? st_mask[nxt_idx[2:0]]
                                                                   : 16'h0000;
      sih_pkg::RK_DIAG: nxt_word = slot_diag;
      default: nxt_word = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= sih_pkg::ST_IDLE;
      kind_ff <= sih_pkg::RK_CFG;
      idx_ff <= 4'h0;
      cnt_ff <= 13'h0000;
      rp_data_ff <= 16'h0000;
      rp_subfn_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      idx_ff <= nxt_idx;
      cnt_ff <= nxt_cnt;
      // A reply word stands until it is taken
      if ((state_ff != sih_pkg::ST_REPLY) || rp_ready)
        rp_data_ff <= nxt_word;
      rp_subfn_ff <= sih_pkg::rply_code(nxt_kind);
    end
  end

  // Network map; each register covers sixteen references
  always_comb
  begin
    nxt_ref[0] = start_ff[0];
    nxt_ref[1] = start_ff[1];
    nxt_ref[2] = start_ff[1] + sih_pkg::REFS_PER_REG;
    nxt_ref[3] = start_ff[2];
    nxt_ref[4] = start_ff[3];
    nxt_ref[5] = start_ff[3] + sih_pkg::REFS_PER_REG;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_ff <= {4{sih_pkg::MAP_START_RST}};
      len_ff <= {sih_pkg::LEN_AQ_RST, sih_pkg::LEN_DQ_RST, sih_pkg::LEN_AI_RST, sih_pkg::LEN_DI_RST};
      mod_ref_ff <= '0;
    end
    else
    begin
      if (wr_map)
      begin
        start_ff[dg_word[1:0]] <= dg_value;
        len_ff[dg_word[1:0]] <= dg_len;
      end
      mod_ref_ff <= nxt_ref;
    end
  end

  // Effective data: forced bits replace field and host data
  always_comb
  begin
    for (int k = 0; k < 3; k++)
    begin
      eff_in[k] = (st_mask[k] & st_val[k]) | (~st_mask[k] & sy2_ff[k]);
      eff_out[k] = (st_mask[k+3] & st_val[k+3]) | (~st_mask[k+3] &
                   (host_online ? host_ff[k] : (hold_last ? last_ff[k] : sih_pkg::DEFAULT_OUT)));
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sy1_ff <= '0;
      sy2_ff <= '0;
      host_ff <= '0;
      last_ff <= '0;
      out_ff <= '0;
      ho_idx_ff <= 2'h0;
      forced_ff <= 1'b0;
    end
    else
    begin
      sy1_ff <= {field_ai1, field_ai0, field_di};
      sy2_ff <= sy1_ff;
      out_ff <= eff_out;
      if (host_online)
        last_ff <= eff_out;
      if (ho_valid)
      begin
        // Host words arrive discrete first, then analog
        host_ff[ho_first ? 2'h0 : ho_idx_ff] <= ho_data;
        ho_idx_ff <= (ho_first ? 2'h1 : ho_idx_ff + 2'h1) % 2'h3;
      end
      forced_ff <= |st_mask;
    end
  end

  // Scan transmit: discrete word, then analog channels
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sc_busy_ff <= 1'b0;
      sc_idx_ff <= 2'h0;
      sc_data_ff <= 16'h0000;
    end
    else if (!sc_busy_ff)
    begin
      if (scan_start)
      begin
        sc_busy_ff <= 1'b1;
        sc_idx_ff <= 2'h0;
        sc_data_ff <= eff_in[0];
      end
    end
    else if (sc_ready)
    begin
      sc_busy_ff <= ~sc_last;
      sc_idx_ff <= sc_idx_ff + 2'h1;
      sc_data_ff <= eff_in[(sc_idx_ff + 2'h1) % 2'h3];
    end
  end

  sih_force_store u_store (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(do_force | do_unforce),
    .wr_idx(tw),
    .wr_mask(new_mask),
    .wr_val(new_val),
    .mask_o(st_mask),
    .val_o(st_val),
    .ready_o(st_ready),
    .nv_we(nv_we),
    .nv_addr(nv_addr),
    .nv_wdata(nv_wdata),
    .nv_rdata(nv_rdata)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_cfg;
    go_cfg |=> rp_valid && rp_subfn == sih_pkg::SF_CFG_RPLY && rp_data == $past(cfg_data);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config reply missing");
  property p_pulse;
    go_pulse |=> pulse_run [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse test not running");
  property p_pulse_done;
    $fell(pulse_run) |-> rp_valid && rp_subfn == sih_pkg::SF_PULSE_DONE;
  endproperty
  a_pulse_done: assert property (p_pulse_done) else $error("pulse complete missing");
  property p_chg;
    (do_force && sf_bsm) |=> rp_valid && rp_subfn == sih_pkg::SF_CFG_CHG;
  endproperty
  a_chg: assert property (p_chg) else $error("config change missing");
  property p_unf_quiet;
    (do_unforce && sf_bsm && new_mask != 16'h0000) |=> !rp_valid;
  endproperty
  a_unf_quiet: assert property (p_unf_quiet) else $error("early change notice");
  property p_map;
    go_map |=> rp_subfn == sih_pkg::SF_MAP_RPLY && rp_data == start_ff[0] && !rp_last;
  endproperty
  a_map: assert property (p_map) else $error("map reply wrong");
  property p_out_force;
    (|st_mask[sih_pkg::W_DQ]) |=>
      ((out_dq ^ $past(st_val[sih_pkg::W_DQ])) & $past(st_mask[sih_pkg::W_DQ])) == 16'h0000;
  endproperty
  a_out_force: assert property (p_out_force) else $error("forced output wrong");
  property p_unforce_src;
    (|($past(st_mask) & ~st_mask)) |-> $past(do_unforce);
  endproperty
  a_unforce_src: assert property (p_unforce_src) else $error("force cleared");
  property p_ignore;
    (take && !sf_force && !sf_unf && !go_cfg && !go_map && !go_frc && !go_diag && !go_pulse
     && !wr_map) |=> !rp_valid && $stable(st_mask) && $stable(start_ff);
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignored code acted");
  property p_forced;
    (|st_mask) |=> forced_active;
  endproperty
  a_forced: assert property (p_forced) else $error("forced flag off");

  c_map: cover property (go_map ##1 (rp_valid && rp_ready) [*8]);
  c_pulse: cover property ($fell(pulse_run));
  c_bsm_last: cover property (bsm_last);
  c_scan: cover property (sc_valid && sc_last && sc_ready);
endmodule : sih_station_handler

/* File: sih_bus_peer.sv */
`timescale 1ns/1ps
module sih_bus_peer (
  input wire logic mclk, // Clock
  output logic dg_valid, // Datagram offered
  input wire logic dg_ready, // Datagram can be taken
  output logic [7:0] dg_subfn, // Code
  output logic dg_from_hhm, // Sender is monitor
  output logic [2:0] dg_word, // Word or map type
  output logic [3:0] dg_bit, // Point
  output logic [15:0] dg_value, // Value or start
  output logic [7:0] dg_len, // Map length
  input wire logic rp_valid, // Reply word present
  output logic rp_ready, // Reply word taken
  input wire logic [7:0] rp_subfn, // Reply code
  input wire logic [15:0] rp_data, // Reply word
  input wire logic rp_last, // Last reply word
  input wire logic slow // Drop reply ready on every other cycle
);
  logic [15:0] got_code;
  logic [15:0] got_first;
  logic got_end;
  logic [15:0] got_n = 16'h0000;
  initial
  begin
    {dg_valid, dg_subfn, dg_from_hhm, dg_word, dg_bit, dg_value, dg_len} = '0;
    rp_ready = 1'b0;
  end
  always @(posedge mclk)
    rp_ready <= slow ? ~rp_ready : 1'b1;
  always @(negedge mclk)
    if (rp_valid === 1'b1 && rp_ready)
    begin
      if (got_n == 16'h0000)
        got_first = rp_data;
      got_code = {8'h00, rp_subfn};
      got_end = rp_last;
      got_n++;
    end
  task automatic send(input logic [7:0] sf, input logic h, input logic [2:0] w,
                      input logic [3:0] b, input logic [15:0] v, input logic [7:0] ln);
    got_n = 16'h0000;
    @(posedge mclk);
    dg_valid <= 1'b1;
    {dg_subfn, dg_from_hhm, dg_word, dg_bit, dg_value, dg_len} <= {sf, h, w, b, v, ln};
    do
      @(negedge mclk);
    while (dg_ready !== 1'b1);
    @(posedge mclk);
    // Released lines show junk, not the last request
    dg_valid <= 1'b0;
    {dg_subfn, dg_from_hhm, dg_word, dg_bit, dg_value, dg_len} <= ~{sf, h, w, b, v, ln};
  endtask : send
endmodule : sih_bus_peer

/* File: io_station_datagram_and_force_handler_test.sv */
`timescale 1ns/1ps
module io_station_datagram_and_force_handler_test;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hhm_force_en = 1'b0;
  logic host_online = 1'b0;
  logic hold_last = 1'b1;
  logic ho_valid = 1'b0;
  logic ho_first = 1'b0;
  logic [15:0] ho_data = 16'h0000;
  logic scan_start = 1'b0;
  logic sc_ready = 1'b1;
  logic slow = 1'b0;
  logic [15:0] cfg_data = 16'h5a3c;
  logic [15:0] slot_diag = 16'h0c71;
  logic [15:0] field_di = 16'h0000;
  logic [15:0] field_ai0 = 16'h1234;
  logic [15:0] field_ai1 = 16'habcd;
  logic dg_valid, dg_ready, dg_from_hhm, rp_valid, rp_ready, rp_last, pulse_run;
  logic sc_valid, sc_last, forced_active, nv_we;
  logic [7:0] dg_subfn, dg_len, rp_subfn;
  logic [2:0] dg_word;
  logic [3:0] dg_bit, nv_addr;
  logic [15:0] dg_value, rp_data, out_dq, out_aq0, out_aq1, sc_data;
  logic [15:0] bsm_force_val, bsm_force_mask, nv_wdata, nv_rdata;
  logic [95:0] mod_ref;
  logic [15:0] nv_mem [16] = '{default: 16'h0000};
  logic [15:0] sw [3];
  logic scl;
  logic [47:0] rows [10] = '{48'h02_00_03_01_5a3c, 48'h02_01_03_01_5a3c,
    48'h2a_00_2b_08_0001, 48'h40_00_41_07_0000, 48'h42_00_43_01_0c71,
    48'h40_01_00_00_0000, 48'h42_01_00_00_0000, 48'h10_00_00_00_0000,
    48'hff_00_00_00_0000, 48'h07_01_00_00_0000};
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  sih_station_handler #(.PULSE_CYC(20)) dut (.mclk, .rst_n, .dg_valid, .dg_ready, .dg_subfn,
    .dg_from_hhm, .dg_word, .dg_bit, .dg_value, .dg_len, .hhm_force_en, .cfg_data, .slot_diag,
    .rp_valid, .rp_ready, .rp_subfn, .rp_data, .rp_last, .pulse_run, .field_di, .field_ai0,
    .field_ai1, .host_online, .hold_last, .ho_valid, .ho_first, .ho_data, .out_dq, .out_aq0,
    .out_aq1, .scan_start, .sc_valid, .sc_ready, .sc_data, .sc_last, .mod_ref, .bsm_force_val,
    .bsm_force_mask, .forced_active, .nv_we, .nv_addr, .nv_wdata, .nv_rdata);
  sih_bus_peer peer (.mclk, .dg_valid, .dg_ready, .dg_subfn, .dg_from_hhm, .dg_word, .dg_bit,
    .dg_value, .dg_len, .rp_valid, .rp_ready, .rp_subfn, .rp_data, .rp_last, .slow);
  // Nonvolatile store keeps its contents through reset
  assign nv_rdata = nv_mem[nv_addr];
  always @(posedge mclk)
    if (nv_we === 1'b1)
      nv_mem[nv_addr] <= nv_wdata;
  initial
    forever #10 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      conclude();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic idle();
    repeat (2) @(negedge mclk);
    for (int k = 0; k < 100 && dg_ready !== 1'b1; k++)
      @(negedge mclk);
  endtask : idle
  task automatic dg(input logic [7:0] sf, input logic h, input logic [2:0] w,
                    input logic [3:0] b, input logic [15:0] v);
    peer.send(sf, h, w, b, v, 8'h05);
    idle();
  endtask : dg
  task automatic host(input logic [47:0] d);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge mclk);
      ho_valid <= 1'b1;
      ho_first <= (i == 0);
      ho_data <= d[47 - 16 * i -: 16];
    end
    @(posedge mclk);
    ho_valid <= 1'b0;
    repeat (2) @(negedge mclk);
  endtask : host
  task automatic scan();
    int n;
    n = 0;
    @(posedge mclk);
    scan_start <= 1'b1;
    @(posedge mclk);
    scan_start <= 1'b0;
    for (int k = 0; k < 20 && n < 3; k++)
    begin
      @(negedge mclk);
      if (sc_valid === 1'b1)
      begin
        sw[n] = sc_data;
        scl = sc_last;
        n++;
      end
    end
  endtask : scan
  task automatic conclude();
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  initial
  begin
    logic [47:0] r;
    int k;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      r = rows[i];
      dg(r[47:40], r[32], 3'h0, 4'h0, 16'h0000);
      check(peer.got_n, {8'h00, r[23:16]});
      if (r[23:16] != 8'h00)
      begin
        check(peer.got_code, {8'h00, r[31:24]});
        check(peer.got_first, r[15:0]);
      end
    end
    k = 0;
    peer.send(8'h10, 1'b1, 3'h0, 4'h0, 16'h0000, 8'h00);
    @(negedge mclk);
    while (pulse_run === 1'b1 && k < 100)
    begin
      k++;
      @(negedge mclk);
    end
    check(16'(k), 16'h0014);
    idle();
    check(peer.got_code, 16'h0011);
    dg(8'h50, 1'b0, 3'h3, 4'h3, 16'h0001);
    check(out_dq, 16'h0008);
    check(nv_mem[6], 16'h0008);
    @(posedge mclk);
    host_online <= 1'b1;
    host(48'h0000_1111_2222);
    check(out_dq, 16'h0008);
    check(out_aq1, 16'h2222);
    check(out_aq0, 16'h1111);
    dg(8'h50, 1'b0, 3'h0, 4'h0, 16'h0001);
    scan();
    check(sw[0], 16'h0001);
    check(sw[1], 16'h1234);
    check(sw[2], 16'habcd);
    check({15'h0000, scl}, 16'h0001);
    check({15'h0000, forced_active}, 16'h0001);
    dg(8'h51, 1'b0, 3'h3, 4'h3, 16'h0000);
    dg(8'h51, 1'b1, 3'h3, 4'h3, 16'h0000);
    dg(8'h50, 1'b1, 3'h3, 4'h2, 16'h0001);
    check(out_dq, 16'h0008);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    idle();
    check(out_dq, 16'h0008);
    @(posedge mclk);
    hhm_force_en <= 1'b1;
    dg(8'h50, 1'b1, 3'h3, 4'h1, 16'h0001);
    @(posedge mclk);
    host_online <= 1'b0;
    dg(8'h51, 1'b1, 3'h3, 4'h1, 16'h0000);
    check(out_dq, 16'h000a);
    dg(8'h51, 1'b1, 3'h3, 4'h3, 16'h0000);
    dg(8'h51, 1'b1, 3'h0, 4'h0, 16'h0000);
    check({15'h0000, forced_active}, 16'h0000);
    dg(8'h1a, 1'b1, 3'h6, 4'h2, 16'h0001);
    check(peer.got_code, 16'h001d);
    dg(8'h1a, 1'b1, 3'h6, 4'h5, 16'h0001);
    check(bsm_force_mask, 16'h0024);
    check(bsm_force_val, 16'h0024);
    dg(8'h1b, 1'b1, 3'h6, 4'h2, 16'h0000);
    check(peer.got_n, 16'h0000);
    dg(8'h1b, 1'b1, 3'h6, 4'h5, 16'h0000);
    check(peer.got_n, 16'h0001);
    @(posedge mclk);
    slow <= 1'b1;
    dg(8'h2c, 1'b0, 3'h0, 4'h0, 16'h0041);
    check(mod_ref[15:0], 16'h0041);
    check(mod_ref[47:32], 16'h0011);
    dg(8'h2c, 1'b0, 3'h2, 4'h0, 16'h0301);
    check(mod_ref[63:48], 16'h0301);
    dg(8'h2a, 1'b0, 3'h0, 4'h0, 16'h0000);
    check(peer.got_first, 16'h0041);
    check(peer.got_n, 16'h0008);
    check({15'h0000, peer.got_end}, 16'h0001);
    conclude();
  end
endmodule : io_station_datagram_and_force_handler_test
